// ---- dv/phylc_far_model.sv ----
/*
  Far-side model: the core status lines feeding the indicator sources.
  Assumes the bench sets lvl, lnk and err just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module phylc_far_model (
  // requests from the bench
  input wire logic sys_clk,
  input wire logic lvl,
  input wire logic lnk,
  input wire logic err,
  // status towards the bank
  output logic link_good,
  output logic any_activity,
  output logic tx_activity,
  output logic rx_activity,
  output logic collision,
  output logic speed_100,
  output logic full_duplex,
  output logic low_power_idle,
  output logic mii_error,
  output logic prbs_error
);
  // one register stage, so the bank never sees a same-edge change
  always_ff @(posedge sys_clk) begin
    link_good <= lnk;
    {any_activity, tx_activity, rx_activity, collision} <= {4{lvl}};
    {speed_100, full_duplex, low_power_idle, mii_error} <= {4{lvl}};
    prbs_error <= err;
  end
endmodule
`default_nettype wire

// ---- dv/phylc_regs_sva.sv ----
/*
  Checker for the configuration bank outputs.
  Bound to phylc_regs; sees only its ports, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module phylc_regs_chk (
  // bus side
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // status and pins
  input wire logic link_good,
  input wire logic prbs_error,
  input wire logic rx_nibble_bit3,
  input wire logic eq_cal_bypass,
  input wire logic [4:0] min_gap_cycles,
  input wire logic [3:0] pad_term_code,
  input wire logic indicator_output_a,
  input wire logic indicator_output_c,
  input wire logic receive_nibble_bit3_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic wr_q, next_wr_q;
  logic [15:0] adr_q;
  logic [3:0] code_a, next_code_a;
  logic [2:0] mux, next_mux;
  // shadow of the fields the assertions depend on
  always_comb begin
    next_wr_q = hsel && hready && htrans == 2'h2 && hwrite && hsize == 3'h2;
    next_code_a = (wr_q && adr_q == 16'h1180) ? hwdata[11:8] : code_a;
    next_mux = (wr_q && adr_q == 16'h1188) ? hwdata[10:8] : mux;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      adr_q <= 16'h0000;
      code_a <= 4'h5;
      mux <= 3'h0;
    end else begin
      wr_q <= next_wr_q;
      adr_q <= haddr;
      code_a <= next_code_a;
      mux <= next_mux;
    end
  end
  property p_eq;
    wr_q && adr_q == 16'h1140 |=> eq_cal_bypass == $past(hwdata[13]);
  endproperty
  a_eq: assert property (p_eq)
    else $error("bypass does not follow bit 13");
  property p_gap;
    wr_q && adr_q == 16'h1158 |=>
      min_gap_cycles == ($past(hwdata[3]) ? 5'h0C : 5'h14);
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap count wrong");
  property p_pad;
    wr_q && adr_q == 16'h1184 |=> pad_term_code == $past(hwdata[4:1]);
  endproperty
  a_pad: assert property (p_pad)
    else $error("termination code wrong");
  property p_link;
    $past(code_a) == 4'h0 |-> indicator_output_a == $past(link_good);
  endproperty
  a_link: assert property (p_link)
    else $error("link source not shown");
  property p_res;
    wr_q && adr_q == 16'h1180 && hwdata[11:8] == 4'hF |->
      ##2 !indicator_output_a;
  endproperty
  a_res: assert property (p_res)
    else $error("reserved code lit indicator");
  property p_lost;
    code_a == 4'hD && $fell(link_good) |-> ##[1:2] indicator_output_a;
  endproperty
  a_lost: assert property (p_lost)
    else $error("link loss not shown");
  property p_pin_ind;
    $past(mux) == 3'h1 |-> receive_nibble_bit3_pin == indicator_output_c;
  endproperty
  a_pin_ind: assert property (p_pin_ind)
    else $error("pin not carrying second indicator");
  property p_pin_norm;
    $past(mux) != 3'h1 |-> receive_nibble_bit3_pin == $past(rx_nibble_bit3);
  endproperty
  a_pin_norm: assert property (p_pin_norm)
    else $error("pin not carrying receive data");
  property p_prbs;
    code_a == 4'hE && prbs_error ##1 code_a == 4'hE |=> indicator_output_a;
  endproperty
  a_prbs: assert property (p_prbs)
    else $error("prbs error not shown");
endmodule
bind phylc_regs phylc_regs_chk u_chk (.sys_clk, .arst_n, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hwdata, .link_good, .prbs_error,
  .rx_nibble_bit3,
  .eq_cal_bypass, .min_gap_cycles, .pad_term_code, .indicator_output_a,
  .indicator_output_c, .receive_nibble_bit3_pin);
`default_nettype wire

// ---- dv/tb.sv ----
/*
  Self-checking bench for the configuration bank over AHB-Lite.
  Assumes the far-side model and the bound checker are compiled too.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import phylc_pkg::*;
  // codes 0-5, 7, A, B, C lit when every status level is high
  localparam logic [15:0] ON_ALL = 16'h1CBF;
  logic sys_clk, arst_n, hsel, hwrite, hreadyout, hresp, lvl, lnk, err;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic link_good, any_activity, tx_activity, rx_activity, collision;
  logic speed_100, full_duplex, low_power_idle, mii_error, prbs_error;
  logic basic_status_read, self_test_clear, rx_nibble_bit3, eq_cal_bypass;
  logic indicator_output_a, indicator_output_c, receive_nibble_bit3_pin;
  logic [4:0] min_gap_cycles;
  logic [3:0] pad_term_code;
  int num_errors = 0, tests_run = 0, cyc = 0;
  logic blink_seen;
  phylc_regs #(.BLINK_CYCLES(4), .STRETCH_CYCLES(8)) dut (.sys_clk, .arst_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .link_good, .any_activity, .tx_activity,
    .rx_activity, .collision, .speed_100, .full_duplex, .low_power_idle,
    .mii_error, .prbs_error, .basic_status_read, .self_test_clear,
    .rx_nibble_bit3, .eq_cal_bypass, .min_gap_cycles, .pad_term_code,
    .indicator_output_a, .indicator_output_c, .receive_nibble_bit3_pin);
  phylc_far_model far (.sys_clk, .lvl, .lnk, .err, .link_good, .any_activity,
    .tx_activity, .rx_activity, .collision, .speed_100, .full_duplex,
    .low_power_idle, .mii_error, .prbs_error);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; the master waits for hready in both phases
  task xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {2'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [11:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(q, {16'h0000, exp});
    chk(hresp, 1'b0);
  endtask
  task settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task pulse(input int k);
    @(posedge sys_clk);
    {err, basic_status_read, self_test_clear} <= 3'h1 << k;
    @(posedge sys_clk);
    {err, basic_status_read, self_test_clear} <= 3'h0;
    settle(3);
  endtask
  task results;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {arst_n, hsel, hwrite, lvl, lnk, err, rx_nibble_bit3} = 7'h0;
    {basic_status_read, self_test_clear, haddr, htrans, hwdata} = '0;
    hsize = HSIZE_WORD;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk(min_gap_cycles, 5'h0C);
    chk(pad_term_code, 4'h8);
    rd(12'h450, RST_DSP_CONFIG_SIX);
    rd(12'h456, RST_GENERAL_CONFIG);
    rd(12'h460, RST_INDICATOR_CONFIG_ONE);
    rd(12'h461, RST_PAD_TERMINATION_CONTROL);
    rd(12'h470, 16'h0000);
    xfer(1'b1, 12'h450, 32'h2141);
    settle(1);
    chk(eq_cal_bypass, 1'b1);
    // bench clears the gap bit, so the 200ns standard gap is selected
    xfer(1'b1, 12'h456, 32'h0);
    settle(1);
    chk(min_gap_cycles, 5'h14);
    xfer(1'b1, 12'h461, 32'h0006);
    rd(12'h461, 16'h0006);
    chk(pad_term_code, 4'h3);
    xfer(1'b1, 12'h460, 32'hFFFF);
    rd(12'h460, 16'h0FFF);
    xfer(1'b1, 12'h462, 32'h0100);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      lvl <= s[0];
      lnk <= s[0];
      for (int c = 0; c < 16; c++) begin
        if (c != 8 && c != 9 && c != 13 && c != 14) begin
          xfer(1'b1, 12'h460, {20'h0, c[3:0], c[3:0], 4'h1});
          settle(2);
          chk(indicator_output_a, ON_ALL[c] & s[0]);
          chk(indicator_output_c, ON_ALL[c] & s[0]);
          chk(receive_nibble_bit3_pin, ON_ALL[c] & s[0]);
        end
      end
    end
    // link with blink, then stretched activity
    xfer(1'b1, 12'h460, 32'h0881);
    settle(2);
    blink_seen = indicator_output_a;
    settle(4);
    chk(indicator_output_a ^ blink_seen, 1'b1);
    @(posedge sys_clk);
    lvl <= 1'b0;
    settle(3);
    chk(indicator_output_a, 1'b1);
    xfer(1'b1, 12'h460, 32'h0991);
    @(posedge sys_clk);
    lvl <= 1'b1;
    settle(4);
    chk(indicator_output_a, 1'b1);
    @(posedge sys_clk);
    lvl <= 1'b0;
    settle(2);
    chk(indicator_output_a, 1'b1);
    settle(12);
    chk(indicator_output_a, 1'b0);
    xfer(1'b1, 12'h460, 32'h0D51);
    @(posedge sys_clk);
    lnk <= 1'b0;
    settle(4);
    @(posedge sys_clk);
    lnk <= 1'b1;
    settle(4);
    chk(indicator_output_a, 1'b1);
    pulse(1);
    chk(indicator_output_a, 1'b0);
    xfer(1'b1, 12'h460, 32'h0E51);
    pulse(0);
    pulse(2);
    chk(indicator_output_a, 1'b1);
    settle(4);
    chk(indicator_output_a, 1'b1);
    pulse(0);
    chk(indicator_output_a, 1'b0);
    xfer(1'b1, 12'h462, 32'h0);
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk);
      rx_nibble_bit3 <= b[0];
      settle(2);
      chk(receive_nibble_bit3_pin, b[0]);
    end
    results();
  end
endmodule
`default_nettype wire

// ---- hw/phylc_regs.sv ----
/*
  Indicator and general configuration bank of a 10/100 transceiver,
  reached over an AHB-Lite slave port with zero wait states.
  Assumes status inputs synchronous to sys_clk, and one-cycle pulses
  from the surrounding core when the basic status register is read and
  when the self-test status register is cleared.
*/
// Notes on behaviour
// - bit 13 set skips equalizer calibration
// - gap bit set 120ns, clear 200ns
// - first indicator source from bits 11:8
// - further source codes, 1111 reserved
// - link lost held until basic status read
// - prbs error held until self-test cleared
// - second indicator source from bits 7:4
// - bits 4:1 give pad termination code
// - rx bit3 pin shows indicator on 001
`timescale 1ns/10ps
`default_nettype none
module phylc_regs
  import phylc_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int STRETCH_CYCLES = STRETCH_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link status from the core
  input wire logic link_good,
  input wire logic any_activity,
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic low_power_idle,
  input wire logic mii_error,
  input wire logic prbs_error,
  input wire logic basic_status_read,
  input wire logic self_test_clear,
  // normal receive data bit 3 from the mac side path
  input wire logic rx_nibble_bit3,
  // outputs to the core and pins
  output logic eq_cal_bypass,
  output logic [4:0] min_gap_cycles,
  output logic [3:0] pad_term_code,
  output logic indicator_output_a,
  output logic indicator_output_c,
  output logic receive_nibble_bit3_pin
);

  logic [15:0] dsp_config_six, next_dsp_config_six;
  logic [15:0] general_config, next_general_config;
  logic [15:0] indicator_config_one, next_indicator_config_one;
  logic [15:0] pad_termination_control, next_pad_termination_control;
  logic [15:0] pin_mux, next_pin_mux;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_idx, next_wr_idx;
  logic [31:0] next_hrdata;
  logic [15:0] rd_val;
  logic [11:0] a_idx;
  logic a_valid;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a_idx = haddr[13:2];
  assign a_valid = hsel && hready && htrans == HTRANS_NONSEQ
    && hsize == HSIZE_WORD;

  // indicator state
  logic link_prev, next_link_prev;
  logic link_lost, next_link_lost;
  logic prbs_hold, next_prbs_hold;
  logic blink, next_blink;
  logic [31:0] blink_cnt, next_blink_cnt;
  logic [31:0] stretch_cnt, next_stretch_cnt;
  logic ind_a, next_ind_a;
  logic ind_c, next_ind_c;
  logic rx_pin, next_rx_pin;
  logic [3:0] src_code [2];
  logic src_val [2];

  // read mux; unmapped words read as zero
  always_comb begin
    case (a_idx)
      IDX_DSP_CONFIG_SIX: rd_val = dsp_config_six;
      IDX_GENERAL_CONFIG: rd_val = general_config;
      IDX_INDICATOR_CONFIG_ONE: rd_val = indicator_config_one;
      IDX_PAD_TERMINATION_CONTROL: rd_val = pad_termination_control;
      IDX_PIN_MUX_STATUS:
        rd_val = pin_mux | {12'h000, ind_c, ind_a, prbs_hold, link_lost};
      default: rd_val = 16'h0000;
    endcase
  end

  // bus and register next state
  always_comb begin
    next_wr_pend = a_valid && hwrite;
    next_wr_idx = a_idx;
    next_hrdata = hrdata;
    if (a_valid && !hwrite) begin
      next_hrdata = {16'h0000, rd_val};
    end
    next_dsp_config_six = dsp_config_six;
    next_general_config = general_config;
    next_indicator_config_one = indicator_config_one;
    next_pad_termination_control = pad_termination_control;
    next_pin_mux = pin_mux;
    if (wr_pend) begin
      case (wr_idx)
        IDX_DSP_CONFIG_SIX: next_dsp_config_six = hwdata[15:0];
        IDX_GENERAL_CONFIG: next_general_config = hwdata[15:0];
        IDX_INDICATOR_CONFIG_ONE:
          next_indicator_config_one = hwdata[15:0] & INDICATOR_RW_MASK;
        IDX_PAD_TERMINATION_CONTROL:
          next_pad_termination_control = hwdata[15:0];
        IDX_PIN_MUX_STATUS: next_pin_mux = hwdata[15:0] & PIN_MUX_RW_MASK;
        default: next_pin_mux = pin_mux;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend <= 1'b0;
      wr_idx <= 12'h000;
      hrdata <= 32'h0000_0000;
      dsp_config_six <= RST_DSP_CONFIG_SIX;
      general_config <= RST_GENERAL_CONFIG;
      indicator_config_one <= RST_INDICATOR_CONFIG_ONE;
      pad_termination_control <= RST_PAD_TERMINATION_CONTROL;
      pin_mux <= RST_PIN_MUX_STATUS;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata <= next_hrdata;
      dsp_config_six <= next_dsp_config_six;
      general_config <= next_general_config;
      indicator_config_one <= next_indicator_config_one;
      pad_termination_control <= next_pad_termination_control;
      pin_mux <= next_pin_mux;
    end
  end

  // configuration outputs straight from the register bits
  assign eq_cal_bypass = dsp_config_six[EQ_BYPASS_BIT];
  // short gaps suit mii only; software keeps to that
  assign min_gap_cycles = general_config[MIN_GAP_BIT] ? IPG_MIN_CYC
    : IPG_STD_CYC;
  assign pad_term_code = pad_termination_control[PAD_TERM_LSB +: 4];

  assign src_code[0] = indicator_config_one[IND_A_LSB +: 4];
  assign src_code[1] = indicator_config_one[IND_C_LSB +: 4];

  // latches, blink and stretch timers
  always_comb begin
    next_link_prev = link_good;
    // a loss in the same cycle as the read still latches
    next_link_lost = (link_prev && !link_good)
      || (link_lost && !basic_status_read);
    next_prbs_hold = prbs_error || (prbs_hold && !self_test_clear);
    next_blink = blink;
    next_blink_cnt = blink_cnt + 32'h0000_0001;
    if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      next_blink_cnt = 32'h0000_0000;
      next_blink = !blink;
    end
    next_stretch_cnt = stretch_cnt;
    if (any_activity) begin
      next_stretch_cnt = 32'(STRETCH_CYCLES);
    end else if (stretch_cnt != 32'h0000_0000) begin
      next_stretch_cnt = stretch_cnt - 32'h0000_0001;
    end
  end

  // source selection, one copy per indicator
  generate
    for (genvar i = 0; i < 2; i++) begin : g_src
      always_comb begin
        case (src_code[i])
          SRC_LINK: src_val[i] = link_good;
          SRC_ACT: src_val[i] = any_activity;
          SRC_TX: src_val[i] = tx_activity;
          SRC_RX: src_val[i] = rx_activity;
          SRC_COL: src_val[i] = collision;
          SRC_SPD100: src_val[i] = link_good && speed_100;
          SRC_SPD10: src_val[i] = link_good && !speed_100;
          SRC_FDX: src_val[i] = full_duplex;
          SRC_LINK_BLINK: src_val[i] = link_good && !(any_activity && blink);
          SRC_STRETCH: src_val[i] = stretch_cnt != 32'h0000_0000;
          SRC_LINK100FD: src_val[i] = link_good && speed_100 && full_duplex;
          SRC_LPI: src_val[i] = low_power_idle;
          SRC_MII_ERR: src_val[i] = mii_error;
          SRC_LINK_LOST: src_val[i] = link_lost;
          SRC_PRBS: src_val[i] = prbs_hold;
          default: src_val[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_ind_a = src_val[0];
    next_ind_c = src_val[1];
    // the pin keeps its data function unless muxed to the indicator
    next_rx_pin = (pin_mux[PIN_MUX_LSB +: 3] == PIN_MUX_INDICATOR)
      ? src_val[1] : rx_nibble_bit3;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_prev <= 1'b0;
      link_lost <= 1'b0;
      prbs_hold <= 1'b0;
      blink <= 1'b0;
      blink_cnt <= 32'h0000_0000;
      stretch_cnt <= 32'h0000_0000;
      ind_a <= 1'b0;
      ind_c <= 1'b0;
      rx_pin <= 1'b0;
    end else begin
      link_prev <= next_link_prev;
      link_lost <= next_link_lost;
      prbs_hold <= next_prbs_hold;
      blink <= next_blink;
      blink_cnt <= next_blink_cnt;
      stretch_cnt <= next_stretch_cnt;
      ind_a <= next_ind_a;
      ind_c <= next_ind_c;
      rx_pin <= next_rx_pin;
    end
  end

  assign indicator_output_a = ind_a;
  assign indicator_output_c = ind_c;
  assign receive_nibble_bit3_pin = rx_pin;

endmodule
`default_nettype wire

// ---- include/phylc_pkg.sv ----
/*
  Constants for the indicator and general configuration bank: register
  indices, reset values, field positions, indicator source codes and
  timing counts. Assumes a 100 MHz core clock.
*/
`default_nettype none
package phylc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_DSP_CONFIG_SIX = 12'h450;
  localparam logic [11:0] IDX_GENERAL_CONFIG = 12'h456;
  localparam logic [11:0] IDX_INDICATOR_CONFIG_ONE = 12'h460;
  localparam logic [11:0] IDX_PAD_TERMINATION_CONTROL = 12'h461;
  localparam logic [11:0] IDX_PIN_MUX_STATUS = 12'h462;

  // reset values
  localparam logic [15:0] RST_DSP_CONFIG_SIX = 16'h0141;
  localparam logic [15:0] RST_GENERAL_CONFIG = 16'h0008;
  localparam logic [15:0] RST_INDICATOR_CONFIG_ONE = 16'h0551;
  localparam logic [15:0] RST_PAD_TERMINATION_CONTROL = 16'h0410;
  localparam logic [15:0] RST_PIN_MUX_STATUS = 16'h0000;

  // field positions
  localparam int EQ_BYPASS_BIT = 13;
  localparam int MIN_GAP_BIT = 3;
  localparam int IND_A_LSB = 8;
  localparam int IND_C_LSB = 4;
  localparam int PAD_TERM_LSB = 1;
  localparam int PIN_MUX_LSB = 8;
  localparam logic [15:0] INDICATOR_RW_MASK = 16'h0FFF;
  localparam logic [15:0] PIN_MUX_RW_MASK = 16'h0700;
  localparam logic [2:0] PIN_MUX_INDICATOR = 3'h1;

  // indicator source codes
  localparam logic [3:0] SRC_LINK = 4'h0;
  localparam logic [3:0] SRC_ACT = 4'h1;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_RX = 4'h3;
  localparam logic [3:0] SRC_COL = 4'h4;
  localparam logic [3:0] SRC_SPD100 = 4'h5;
  localparam logic [3:0] SRC_SPD10 = 4'h6;
  localparam logic [3:0] SRC_FDX = 4'h7;
  localparam logic [3:0] SRC_LINK_BLINK = 4'h8;
  localparam logic [3:0] SRC_STRETCH = 4'h9;
  localparam logic [3:0] SRC_LINK100FD = 4'hA;
  localparam logic [3:0] SRC_LPI = 4'hB;
  localparam logic [3:0] SRC_MII_ERR = 4'hC;
  localparam logic [3:0] SRC_LINK_LOST = 4'hD;
  localparam logic [3:0] SRC_PRBS = 4'hE;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int IPG_MIN_NS = 120;
  localparam int IPG_STD_NS = 200;
  localparam logic [4:0] IPG_MIN_CYC = 5'((IPG_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] IPG_STD_CYC = 5'((IPG_STD_NS * CLK_MHZ + 999) / 1000);
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
  localparam int STRETCH_MS = 50;
  localparam int STRETCH_CYC = STRETCH_MS * CLK_MHZ * 1000;

  // ahb-lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire
